// >>> common/scb_pkg.sv
/*
 * Package for the strap configuration and bus setup block: register
 * offsets, field positions, reset values and carrier structs.
 * Assumes a single clk_in domain with synchronous active-high reset.
 */
package scb_pkg;

    // Register offsets (host I/O addresses)
    localparam logic [15:0] SCB_ADDR_ID_LO     = 16'h0100;
    localparam logic [15:0] SCB_ADDR_ID_HI     = 16'h0101;
    localparam logic [15:0] SCB_ADDR_CARD_EN   = 16'h0102;
    localparam logic [15:0] SCB_ADDR_EC2       = 16'h0104;
    localparam logic [15:0] SCB_ADDR_EC3       = 16'h0106;
    localparam logic [15:0] SCB_ADDR_DISPLAY_STATUS_REG = 16'h0108;
    localparam logic [15:0] SCB_ADDR_SUBS_STAT = 16'h010A;

    // extended_config_two, EC3 and status field positions
    localparam int SCB_EC2_ROM_BASE_SELECT_LO = 3;
    localparam int SCB_EC2_ROM_WINDOW_SIZE    = 5;
    localparam int SCB_EC2_ROMPAGE    = 6;
    localparam int SCB_EC2_PLANES     = 7;
    localparam int SCB_EC2_BANKS_LO   = 8;
    localparam int SCB_EC2_VRAM1M     = 10;
    localparam int SCB_EC2_DAC8       = 13;
    localparam int SCB_EC3_MONID_LO   = 13;
    localparam int SCB_SUB_MONID_LO   = 4;
    localparam int SCB_SUB_PLANES     = 7;

    localparam logic [2:0]  SCB_ROM_PAGE_ID    = 3'h1;
    localparam logic [1:0]  SCB_BANKS_ONE      = 2'h0;
    localparam logic [1:0]  SCB_BANKS_TWO      = 2'h1;
    localparam logic [1:0]  SCB_BANKS_FOUR     = 2'h2;
    localparam logic [7:0]  SCB_CARD_EN_RESET  = 8'h00;
    localparam logic [15:0] SCB_EC3_RESET      = 16'h0000;

    // ROM window bases, upper address bits [19:12]
    localparam logic [7:0] SCB_BASE_C0 = 8'hC0;
    localparam logic [7:0] SCB_BASE_C6 = 8'hC6;
    localparam logic [7:0] SCB_BASE_C8 = 8'hC8;
    localparam logic [7:0] SCB_BASE_D0 = 8'hD0;
    localparam logic [7:0] SCB_BASE_D8 = 8'hD8;
    localparam logic [7:0] SCB_MASK_8K  = 8'hFE;
    localparam logic [7:0] SCB_MASK_32K = 8'hF8;

    typedef enum logic [1:0] {
        SCB_BUS_ISA,
        SCB_BUS_CHANNEL,
        SCB_BUS_UNIFIED_ISA_MODE
    } scb_bus_e;

    typedef enum logic [1:0] {
        SCB_LANE_WORD,
        SCB_LANE_EVEN,
        SCB_LANE_ODD_HIGH,
        SCB_LANE_ODD_LOW
    } scb_lane_e;

    // Strap pins as seen while reset is held
    typedef struct packed {
        logic       bus_type_strap;
        logic       vram_size_strap;
        logic       column_strobe_bank3_n;
        logic       column_strobe_bank2_n;
        logic       dac_width_strap;
        logic       rom_chip_select_n;
        logic       nibble_mode_strap;
        logic [7:0] pixel_bus;
    } scb_straps_s;

    // Host bus request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        a0;
        logic        bhe_n;
        logic [15:0] addr;
        logic [15:0] wdata;
    } scb_req_s;

endpackage : scb_pkg

// >>> rtl/scb_sync.sv
/*
 * Two flip-flop synchroniser, one per bit via a generate loop.
 * Assumes asynchronous inputs and the shared clk_in domain.
 */
`timescale 1ns/1ps
`default_nettype none
module scb_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic             clk_en_in,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_val_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    meta_reg[i] <= 1'b1;
                    sync_out[i] <= 1'b1;
                end else if (clk_en_in) begin
                    meta_reg[i] <= async_in[i];
                    sync_out[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    logic unused_reset_val;
    assign unused_reset_val = ^reset_val_in;
endmodule : scb_sync
`default_nettype wire

// >>> rtl/scb_strap_cfg.sv
/*
 * Strap capture, setup-cycle card enable, byte lane decode, bus type
 * selection and ROM window decode for the accelerator.
 * Assumes a host bus synchronous to clk_in and straps driven by the
 * board while sys_rst_in is high; pins are sampled through scb_sync.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Setup read of 100h/101h selects ROM, bank 1
// - Card enable is bit 0 at setup_card_enable
// - Setup registers byte-only, absent in ISA mode
// - A0/BHE decode gives word or byte lanes
// - Bus strap low selects unified ISA mode
// - Bus type is never readable
// - VRAM size strap held at EC2 bit 10
// - Small VRAM forces legacy organisation only
// - Bank strobe straps give bank count
// - Interleave low bit picks nugget width
// - DAC width latched, driven back, RW
// - Sense and monitor id in status registers
// - Monitor id RW in EC3, paging EC2[6]
// - Nibble strap low enables five extra pins
// - Pixel bits 7..3 straps, undriven default one
// - Plane strap in status bit 7 and EC2[7]
// - ROM size strap picks 8K or 32K
// - ROM select low at reset disables ROM
// - ROM base field selects window base
// - Straps captured at reset falling edge
// - Soft reset leaves straps untouched
module scb_strap_cfg
    import scb_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        clk_en_in,
    input  wire scb_straps_s straps_in,
    input  wire logic        setup_sel_n_in,
    input  wire logic        isa_mode_pin_in,
    input  wire logic        sense_in,
    input  wire logic [2:0]  monitor_id_pins_in,
    input  wire logic        soft_reset_in,
    input  wire scb_req_s    req_in,
    input  wire logic [7:0]  mem_addr_hi_in,
    input  wire logic [3:0]  memory_control_in,
    output logic [15:0]      rdata_out,
    output logic             rvalid_out,
    output scb_lane_e        lane_out,
    output logic             rom_chip_select_n_out,
    output logic [2:0]       rom_page_sel_out,
    output logic             rom_window_hit_out,
    output logic             card_enable_out,
    output logic             dac_width_out,
    output logic             dac_width_oe_out,
    output logic             nibble_pins_en_out,
    output logic             legacy_only_out,
    output logic             five_pixel_nugget_out,
    output logic             id_buffer_enable_n_out
);

    scb_straps_s straps_sync;
    logic        setup_n_sync;
    logic        isa_pin_sync;
    logic        sense_sync;
    logic [2:0]  monid_sync;

    scb_sync #(.WIDTH($bits(scb_straps_s) + 6)) u_sync (
        .clk_in       (clk_in),
        .sys_rst_in   (1'b0),
        .clk_en_in    (clk_en_in),
        .async_in     ({straps_in, setup_sel_n_in, isa_mode_pin_in,
                        sense_in, monitor_id_pins_in}),
        .reset_val_in ('1),
        .sync_out     ({straps_sync, setup_n_sync, isa_pin_sync,
                        sense_sync, monid_sync})
    );

    logic        rst_d_reg;
    logic        capture;
    logic [15:0] ec2_reg;
    logic [15:0] ec3_reg;
    logic [7:0]  card_en_reg;
    logic        plane_status_reg;
    logic        bus_strap_reg;
    logic        nibble_reg;
    logic        rom_absent_reg;
    logic        setup_strap_reg;
    scb_bus_e    bus_type;

    // Falling edge of reset: first enabled cycle after release
    always_ff @(posedge clk_in) begin
        if (clk_en_in) begin
            rst_d_reg <= sys_rst_in;
        end
    end
    assign capture = clk_en_in && rst_d_reg && !sys_rst_in;

    logic is_wr;
    logic setup_ok;
    logic byte_acc;
    assign is_wr    = req_in.wr && clk_en_in;
    assign byte_acc = !(req_in.a0 == 1'b0 && req_in.bhe_n == 1'b0);
    assign setup_ok = !setup_n_sync && bus_type != SCB_BUS_ISA && byte_acc;

    // Soft reset deliberately does not reload straps or touch this state
    always_ff @(posedge clk_in) begin
        if (capture) begin
            ec2_reg <= '0;
            ec2_reg[SCB_EC2_DAC8]    <= straps_sync.dac_width_strap;
            ec2_reg[SCB_EC2_VRAM1M]  <= straps_sync.vram_size_strap;
            ec2_reg[SCB_EC2_PLANES]  <= straps_sync.pixel_bus[7];
            ec2_reg[SCB_EC2_ROMPAGE] <= straps_sync.pixel_bus[6];
            ec2_reg[SCB_EC2_ROM_WINDOW_SIZE] <= straps_sync.pixel_bus[5];
            ec2_reg[SCB_EC2_ROM_BASE_SELECT_LO +: 2] <= straps_sync.pixel_bus[4:3];
            if (!straps_sync.column_strobe_bank3_n && !straps_sync.column_strobe_bank2_n) begin
                ec2_reg[SCB_EC2_BANKS_LO +: 2] <= SCB_BANKS_ONE;
            end else if (!straps_sync.column_strobe_bank3_n) begin
                ec2_reg[SCB_EC2_BANKS_LO +: 2] <= SCB_BANKS_TWO;
            end else begin
                ec2_reg[SCB_EC2_BANKS_LO +: 2] <= SCB_BANKS_FOUR;
            end
        end else if (is_wr && req_in.addr == SCB_ADDR_EC2) begin
            ec2_reg <= req_in.wdata;
        end
    end

    always_ff @(posedge clk_in) begin
        if (capture) begin
            plane_status_reg <= straps_sync.pixel_bus[7];
            bus_strap_reg    <= straps_sync.bus_type_strap;
            nibble_reg       <= straps_sync.nibble_mode_strap;
            rom_absent_reg   <= !straps_sync.rom_chip_select_n;
            // Setup select is grounded for ISA; sampling it live would turn every
            // channel-bus setup cycle into an ISA cycle
            setup_strap_reg  <= setup_n_sync;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ec3_reg <= SCB_EC3_RESET;
        end else if (capture) begin
            ec3_reg[SCB_EC3_MONID_LO +: 3] <= monid_sync;
        end else if (is_wr && req_in.addr == SCB_ADDR_EC3) begin
            ec3_reg <= req_in.wdata;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || (clk_en_in && soft_reset_in)) begin
            card_en_reg <= SCB_CARD_EN_RESET;
        end else if (is_wr && req_in.addr == SCB_ADDR_CARD_EN && setup_ok) begin
            card_en_reg <= {7'h00, req_in.wdata[0]};
        end
    end

    // Bus type is internal only; no read path carries it
    always_comb begin
        if (!bus_strap_reg) begin
            bus_type = SCB_BUS_UNIFIED_ISA_MODE;
        end else if (setup_strap_reg) begin
            bus_type = SCB_BUS_CHANNEL;
        end else begin
            bus_type = SCB_BUS_ISA;
        end
    end

    always_comb begin
        case ({req_in.a0, req_in.bhe_n})
            2'b00:   lane_out = SCB_LANE_WORD;
            2'b01:   lane_out = SCB_LANE_EVEN;
            2'b10:   lane_out = SCB_LANE_ODD_HIGH;
            default: lane_out = SCB_LANE_ODD_LOW;
        endcase
    end

    logic id_read;
    assign id_read = req_in.rd && !setup_n_sync &&
                     (req_in.addr == SCB_ADDR_ID_LO || req_in.addr == SCB_ADDR_ID_HI);

    logic [1:0] rbase;
    logic       rsize8k;
    logic [7:0] base;
    logic [7:0] mask;
    assign rbase   = ec2_reg[SCB_EC2_ROM_BASE_SELECT_LO +: 2];
    assign rsize8k = ec2_reg[SCB_EC2_ROM_WINDOW_SIZE];

    always_comb begin
        case (rbase)
            2'b00: base = !rsize8k ? SCB_BASE_D0 :
                          (bus_type == SCB_BUS_CHANNEL ? SCB_BASE_C8 : SCB_BASE_C6);
            2'b01: base = SCB_BASE_D8;
            2'b10: base = SCB_BASE_C0;
            default: base = (rsize8k && bus_type == SCB_BUS_CHANNEL) ? SCB_BASE_C6
                                                                   : SCB_BASE_C8;
        endcase
        mask = rsize8k ? SCB_MASK_8K : SCB_MASK_32K;
    end

    assign rom_window_hit_out = !rom_absent_reg && !sys_rst_in &&
                                ((mem_addr_hi_in & mask) == (base & mask));

    assign rom_chip_select_n_out  = !(id_read && setup_ok) && !rom_window_hit_out;
    assign id_buffer_enable_n_out = !(id_read && setup_ok);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rom_page_sel_out <= '0;
        end else if (clk_en_in && id_read && setup_ok) begin
            rom_page_sel_out <= SCB_ROM_PAGE_ID;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_out  <= '0;
            rvalid_out <= 1'b0;
        end else if (clk_en_in) begin
            rvalid_out <= req_in.rd;
            rdata_out  <= '0;
            if (req_in.addr == SCB_ADDR_CARD_EN && setup_ok) begin
                rdata_out <= {8'h00, card_en_reg};
            end else if (req_in.addr == SCB_ADDR_EC2) begin
                rdata_out <= ec2_reg;
            end else if (req_in.addr == SCB_ADDR_EC3) begin
                rdata_out <= ec3_reg;
            end else if (req_in.addr == SCB_ADDR_DISPLAY_STATUS_REG) begin
                rdata_out <= {15'h0000, sense_sync};
            end else if (req_in.addr == SCB_ADDR_SUBS_STAT) begin
                rdata_out <= {8'h00, plane_status_reg,
                              (ec2_reg[SCB_EC2_ROMPAGE] ? ec3_reg[SCB_EC3_MONID_LO +: 3]
                                                        : monid_sync), 4'h0};
            end
        end
    end

    assign card_enable_out       = card_en_reg[0];
    assign dac_width_out         = ec2_reg[SCB_EC2_DAC8];
    assign dac_width_oe_out      = !sys_rst_in;
    assign nibble_pins_en_out    = !nibble_reg;
    assign legacy_only_out       = !ec2_reg[SCB_EC2_VRAM1M];
    assign five_pixel_nugget_out = memory_control_in[0];

    logic unused_bits;
    assign unused_bits = isa_pin_sync ^ ^memory_control_in[3:1];
endmodule : scb_strap_cfg
`default_nettype wire

// >>> verif/scb_board.sv
/* Board strap drivers for the strap block.
 * Assumes straps are driven only while reset_out_in is high. */
`timescale 1ns/1ps
`default_nettype none
module scb_board
    import scb_pkg::*;
(
    input  wire logic  clk_in,
    input  wire logic  reset_out_in,
    input  wire logic  cfg_b_in,
    output scb_straps_s straps_out
);
    logic [7:0] pix_reg = 8'h00;
    // Pixel and strobe pins carry live traffic once reset is over
    always_ff @(posedge clk_in) pix_reg <= pix_reg + 8'h35;
    always_comb begin
        if (reset_out_in) begin
            straps_out = cfg_b_in ? 15'h0800 : 15'h7FFF;
        end else begin
            // Pull-ups give 1; the unpulled width pin shows the inverse of its last level
            straps_out = {2'b11, pix_reg[1:0], cfg_b_in, 2'b11, pix_reg};
        end
    end
endmodule : scb_board
`default_nettype wire

// >>> verif/scb_strap_cfg_sva.sv
/* Port checker for scb_strap_cfg.
 * Assumes clk_en_in is held high and setup select stays high in reset. */
`timescale 1ns/1ps
`default_nettype none
module scb_strap_cfg_sva
    import scb_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire scb_straps_s straps_in,
    input wire logic        setup_sel_n_in,
    input wire logic        soft_reset_in,
    input wire scb_req_s    req_in,
    input wire logic [15:0] rdata_out,
    input wire logic        rvalid_out,
    input wire scb_lane_e   lane_out,
    input wire logic        rom_chip_select_n_out,
    input wire logic [2:0]  rom_page_sel_out,
    input wire logic        rom_window_hit_out,
    input wire logic        card_enable_out,
    input wire logic        dac_width_out,
    input wire logic        dac_width_oe_out,
    input wire logic        nibble_pins_en_out,
    input wire logic        id_buffer_enable_n_out
);
    logic       chan_reg;
    logic       romoff_reg;
    logic [1:0] run_reg;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            chan_reg   <= straps_in.bus_type_strap & setup_sel_n_in;
            romoff_reg <= ~straps_in.rom_chip_select_n;
        end
    end
    // Edges since reset release, saturating; covers the synchroniser delay
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) run_reg <= 2'h0;
        else if (run_reg != 2'h3) run_reg <= run_reg + 2'h1;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    wire card_a = req_in.addr == SCB_ADDR_CARD_EN;
    property p_lane;
        req_in.rd |-> lane_out == (req_in.a0 ? (req_in.bhe_n ? SCB_LANE_ODD_LOW
            : SCB_LANE_ODD_HIGH) : (req_in.bhe_n ? SCB_LANE_EVEN : SCB_LANE_WORD));
    endproperty
    a_lane: assert property (p_lane) else $error("lane decode wrong");
    property p_id_sel;
        chan_reg && req_in.rd && req_in.addr[15:1] == 15'h0080 && !setup_sel_n_in
            && $past(setup_sel_n_in, 3) == 1'b0 && $past(setup_sel_n_in, 2) == 1'b0
            |-> !rom_chip_select_n_out && !id_buffer_enable_n_out
            ##1 rom_page_sel_out == SCB_ROM_PAGE_ID;
    endproperty
    a_id_sel: assert property (p_id_sel) else $error("id read not from rom");
    property p_card_wr;
        chan_reg && req_in.wr && card_a && !req_in.a0 && req_in.bhe_n && !soft_reset_in
            && !setup_sel_n_in && $past(setup_sel_n_in, 3) == 1'b0
            && $past(setup_sel_n_in, 2) == 1'b0 |=> card_enable_out == $past(req_in.wdata[0]);
    endproperty
    a_card_wr: assert property (p_card_wr) else $error("card enable not written");
    property p_card_ign;
        req_in.wr && card_a && setup_sel_n_in && $past(setup_sel_n_in, 3)
            && $past(setup_sel_n_in, 2) && !soft_reset_in |=> $stable(card_enable_out);
    endproperty
    a_card_ign: assert property (p_card_ign) else $error("card enable took write");
    property p_word_ref;
        req_in.rd && card_a && !req_in.a0 && !req_in.bhe_n |=> rvalid_out && rdata_out == 16'h0000;
    endproperty
    a_word_ref: assert property (p_word_ref) else $error("word setup read answered");
    property p_dac_oe;
        run_reg != 2'h0 |-> dac_width_oe_out;
    endproperty
    a_dac_oe: assert property (p_dac_oe) else $error("width pin not driven");
    property p_dac_hold;
        run_reg == 2'h3 && !$past(req_in.wr) && !$past(req_in.wr, 2) |-> $stable(dac_width_out);
    endproperty
    a_dac_hold: assert property (p_dac_hold) else $error("width pin moved");
    property p_nibble;
        run_reg == 2'h3 |-> $stable(nibble_pins_en_out);
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble enable moved");
    property p_no_rom;
        romoff_reg && run_reg == 2'h3 |-> !rom_window_hit_out;
    endproperty
    a_no_rom: assert property (p_no_rom) else $error("rom mapped while off");
    c_card: cover property (req_in.wr && card_a ##1 card_enable_out);
    c_id: cover property (req_in.rd && !rom_chip_select_n_out);
    c_hit: cover property (rom_window_hit_out);
endmodule : scb_strap_cfg_sva
bind scb_strap_cfg scb_strap_cfg_sva u_sva (.*);
`default_nettype wire

// >>> verif/scb_strap_cfg_test.sv
/* Self-checking bench for scb_strap_cfg.
 * Assumes scb_board drives straps during reset and the checker is bound. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module scb_strap_cfg_test
    import scb_pkg::*;
;
    logic        clk_in = 1'b0, sys_rst_in = 1'b1, setup_sel_n_in = 1'b1, cfg_b = 1'b1;
    logic        sense_in = 1'b0, soft_reset_in = 1'b0;
    logic [2:0]  mon_id = 3'h0, page;
    logic [7:0]  mem_hi = 8'h00;
    logic [3:0]  mem_ctl = 4'h0;
    logic [15:0] rdata, v;
    logic        rvalid, rom_chip_select_n_n, hit, card_en, dac, dac_oe, nib, legacy, five, idb_n;
    scb_req_s    req = '0;
    scb_straps_s board, straps;
    scb_lane_e   lane;
    int          failures = 0, n_tests = 0;
    scb_lane_e   lx[4] = '{SCB_LANE_WORD, SCB_LANE_EVEN, SCB_LANE_ODD_HIGH, SCB_LANE_ODD_LOW};
    logic [7:0]  bx[4] = '{8'hC8, 8'hD8, 8'hC0, 8'hC6};
    // The width pin is shared: the device drives it once out of reset
    always_comb begin
        straps = board;
        if (dac_oe) straps.dac_width_strap = dac;
    end
    initial forever #5 clk_in = ~clk_in;
    scb_board u_board (.clk_in(clk_in), .reset_out_in(sys_rst_in), .cfg_b_in(cfg_b),
        .straps_out(board));
    scb_strap_cfg DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
        .straps_in(straps), .setup_sel_n_in(setup_sel_n_in), .isa_mode_pin_in(1'b0),
        .sense_in(sense_in), .monitor_id_pins_in(mon_id), .soft_reset_in(soft_reset_in),
        .req_in(req), .mem_addr_hi_in(mem_hi), .memory_control_in(mem_ctl), .rdata_out(rdata),
        .rvalid_out(rvalid), .lane_out(lane), .rom_chip_select_n_out(rom_chip_select_n_n),
        .rom_page_sel_out(page), .rom_window_hit_out(hit), .card_enable_out(card_en),
        .dac_width_out(dac), .dac_width_oe_out(dac_oe), .nibble_pins_en_out(nib),
        .legacy_only_out(legacy), .five_pixel_nugget_out(five),
        .id_buffer_enable_n_out(idb_n));
    task report_and_stop;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task bus(input logic r, w, a0, bhe, input logic [15:0] a, d);
        @(posedge clk_in) req <= '{r, w, a0, bhe, a, d};
        @(posedge clk_in) req <= '0;
        #1;
    endtask : bus
    task edge_wait(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : edge_wait
    task t_straps(input logic b, input logic [15:0] ec2e);
        @(posedge clk_in) cfg_b <= b;
        sys_rst_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        mem_hi <= 8'hC6;
        edge_wait(3);
        bus(1, 0, 0, 0, SCB_ADDR_EC2, 16'h0);
        `CHK(rdata & 16'h27F8, ec2e)
        `CHK(dac, ~b)
        `CHK(nib, b)
        `CHK(legacy, b)
        `CHK(hit, ~b)
        bus(1, 0, 0, 0, SCB_ADDR_SUBS_STAT, 16'h0);
        `CHK(rdata[7], ~b)
        $display("test straps done");
    endtask : t_straps
    task t_lanes;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in) req <= '{1'b1, 1'b0, i[1], i[0], SCB_ADDR_DISPLAY_STATUS_REG, 16'h0};
            #1 `CHK(lane, lx[i])
        end
        @(posedge clk_in) req <= '0;
        $display("test lanes done");
    endtask : t_lanes
    task t_setup;
        @(posedge clk_in) setup_sel_n_in <= 1'b0;
        edge_wait(3);
        bus(0, 1, 0, 1, SCB_ADDR_CARD_EN, 16'h0001);
        `CHK(card_en, 1'b1)
        bus(1, 0, 0, 1, SCB_ADDR_CARD_EN, 16'h0);
        `CHK(rdata[0], 1'b1)
        bus(1, 0, 0, 0, SCB_ADDR_CARD_EN, 16'h0);
        `CHK(rdata, 16'h0000)
        @(posedge clk_in) req <= '{1'b1, 1'b0, 1'b0, 1'b1, SCB_ADDR_ID_HI, 16'h0};
        #1 `CHK({rom_chip_select_n_n, idb_n}, 2'b00)
        @(posedge clk_in) req <= '0;
        #1 `CHK(page, SCB_ROM_PAGE_ID)
        @(posedge clk_in) setup_sel_n_in <= 1'b1;
        edge_wait(3);
        bus(0, 1, 0, 1, SCB_ADDR_CARD_EN, 16'h0000);
        `CHK(card_en, 1'b1)
        @(posedge clk_in) soft_reset_in <= 1'b1;
        @(posedge clk_in) soft_reset_in <= 1'b0;
        edge_wait(1);
        `CHK(card_en, 1'b0)
        $display("test setup done");
    endtask : t_setup
    task t_rom;
        bus(1, 0, 0, 0, SCB_ADDR_EC2, 16'h0);
        v = rdata;
        for (int i = 0; i < 4; i++) begin
            bus(0, 1, 0, 0, SCB_ADDR_EC2, (v & ~16'h0018) | 16'(i << 3));
            mem_hi <= bx[i];
            edge_wait(1);
            `CHK(hit, 1'b1)
            mem_hi <= bx[i] + 8'h02;
            edge_wait(1);
            `CHK(hit, 1'b0)
        end
        v = v & ~16'h2038;
        bus(0, 1, 0, 0, SCB_ADDR_EC2, v);
        mem_hi <= 8'hD7;
        edge_wait(1);
        `CHK({hit, dac}, 2'b10)
        @(posedge clk_in) soft_reset_in <= 1'b1;
        @(posedge clk_in) soft_reset_in <= 1'b0;
        bus(1, 0, 0, 0, SCB_ADDR_EC2, 16'h0);
        `CHK(rdata & 16'h27F8, v & 16'h27F8)
        $display("test rom done");
    endtask : t_rom
    task t_status;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_in) sense_in <= i[0];
            mon_id <= 3'h2;
            mem_ctl <= {3'h4, i[0]};
            bus(0, 1, 0, 0, SCB_ADDR_EC2, i[0] ? (v | 16'h0040) : (v & ~16'h0040));
            bus(0, 1, 0, 0, SCB_ADDR_EC3, 16'hA000);
            edge_wait(4);
            `CHK(five, i[0])
            bus(1, 0, 0, 0, SCB_ADDR_DISPLAY_STATUS_REG, 16'h0);
            `CHK(rdata[0], i[0])
            bus(1, 0, 0, 0, SCB_ADDR_SUBS_STAT, 16'h0);
            `CHK(rdata[6:4], i[0] ? 3'h5 : 3'h2)
        end
        $display("test status done");
    endtask : t_status
    initial begin
        t_straps(1'b1, 16'h0100);
        t_straps(1'b0, 16'h26F8);
        t_lanes();
        t_setup();
        t_rom();
        t_status();
        report_and_stop();
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        failures++;
        report_and_stop();
    end
endmodule : scb_strap_cfg_test
`default_nettype wire
